// >>> bit_skip_clear_call_exec.sv
// two-slot fetch/execute core for bit test skip, register clear and call
// assumes program memory returns the word at pc_o in the same cycle and the
// register file answers rf_addr_o combinationally on rf_rdata_i
`timescale 1ns/100ps
module bit_skip_clear_call_exec (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [13:0] instr_i,
   input wire logic [7:0] rf_rdata_i,
   input wire logic [4:0] pc_page_latch_i,
   output logic [12:0] pc_o,
   output logic [6:0] rf_addr_o,
   output logic rf_we_o,
   output logic [6:0] rf_waddr_o,
   output logic [7:0] rf_wdata_o,
   output logic zero_set_o,
   output logic push_o,
   output logic [12:0] stack_top_o,
   output logic bubble_o
);
   // ************************************************************
   // decode of the execute slot
   // ************************************************************
   decode_if dif ();
   instr_field_decoder u_dec (
      .d(dif.dec)
   );

   logic [13:0] ir_q, ir_d;
   logic [12:0] pc_q, pc_d;
   logic [6:0] rf_addr_q, rf_addr_d;
   logic rf_we_q, rf_we_d;
   logic [6:0] rf_waddr_q, rf_waddr_d;
   logic zero_set_q, zero_set_d;
   logic push_q, push_d;
   logic [12:0] stack_top_q, stack_top_d;
   logic bubble_q, bubble_d;
   logic [7:0] rf_wdata_q, rf_wdata_d;
   logic live_q, live_d;
   logic is_skip, is_clear, is_call, bit_set;

   assign dif.instr = ir_q;
   assign is_skip = dif.kind == core_exec_pkg::OP_BIT_TEST_SKIP_SET;
   assign is_clear = dif.kind == core_exec_pkg::OP_CLEAR_DATA_REGISTER;
   assign is_call = dif.kind == core_exec_pkg::OP_CALL;
   // the operand address was registered at fetch, so the read is ready now
   assign bit_set = rf_rdata_i[dif.bsel];

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      pc_d = pc_q + core_exec_pkg::PC_STEP;
      ir_d = instr_i;
      bubble_d = 1'b0;
      rf_we_d = 1'b0;
      rf_waddr_d = dif.faddr;
      zero_set_d = 1'b0;
      push_d = 1'b0;
      stack_top_d = stack_top_q;
      // write data is fixed, but kept in a flop so the pin is registered
      rf_wdata_d = core_exec_pkg::CLEAR_VALUE;
      live_d = 1'b1;
      if (is_skip && bit_set) begin
         ir_d = core_exec_pkg::NOP_WORD;
         bubble_d = 1'b1;
      end else if (is_clear) begin
         rf_we_d = 1'b1;
         zero_set_d = 1'b1;
      end else if (is_call) begin
         // pc_q already points one past the call, which is the return address
         push_d = 1'b1;
         stack_top_d = pc_q;
         pc_d = {pc_page_latch_i[core_exec_pkg::LATCH_PAGE_LSB +: 2],
                 dif.kaddr};
         ir_d = core_exec_pkg::NOP_WORD;
         bubble_d = 1'b1;
      end
      rf_addr_d = ir_d[core_exec_pkg::FADDR_W-1:0];
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pc_q <= core_exec_pkg::PC_RESET;
         ir_q <= core_exec_pkg::NOP_WORD;
         rf_addr_q <= '0;
         rf_we_q <= 1'b0;
         rf_waddr_q <= '0;
         zero_set_q <= 1'b0;
         push_q <= 1'b0;
         stack_top_q <= core_exec_pkg::PC_RESET;
         bubble_q <= 1'b0;
         rf_wdata_q <= core_exec_pkg::CLEAR_VALUE;
         live_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         ir_q <= ir_d;
         rf_addr_q <= rf_addr_d;
         rf_we_q <= rf_we_d;
         rf_waddr_q <= rf_waddr_d;
         zero_set_q <= zero_set_d;
         push_q <= push_d;
         stack_top_q <= stack_top_d;
         bubble_q <= bubble_d;
         rf_wdata_q <= rf_wdata_d;
         live_q <= live_d;
      end
   end

   assign pc_o = pc_q;
   assign rf_addr_o = rf_addr_q;
   assign rf_we_o = rf_we_q;
   assign rf_waddr_o = rf_waddr_q;
   assign rf_wdata_o = rf_wdata_q;
   assign zero_set_o = zero_set_q;
   assign push_o = push_q;
   assign stack_top_o = stack_top_q;
   assign bubble_o = bubble_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   // reset may fall at an edge the core still spends in reset, so checks
   // wait until one edge has run with reset low
   default disable iff (sys_rst_i || !live_q);

   chk_skip_taken: assert property (
      is_skip && bit_set |=> bubble_q && ir_q == core_exec_pkg::NOP_WORD)
      else $error("skip with bit set did not drop prefetched word");
   chk_skip_not_taken: assert property (
      is_skip && !bit_set |=> !bubble_q && ir_q == $past(instr_i))
      else $error("skip with bit clear disturbed the flow");
   chk_skip_one_slot: assert property (
      is_skip && bit_set |=> ##1 !bubble_q)
      else $error("skip lasted more than two cycles");
   chk_clear_write: assert property (
      is_clear |=> rf_we_o && rf_wdata_o == core_exec_pkg::CLEAR_VALUE
                   && rf_waddr_o == $past(dif.faddr) && zero_set_o)
      else $error("clear did not write zero and set zero flag");
   chk_clear_single: assert property (
      is_clear |=> !bubble_q ##1 !rf_we_o || $past(is_clear))
      else $error("clear took more than one cycle");
   chk_call_push: assert property (
      is_call |=> push_o && stack_top_o == $past(pc_q))
      else $error("call pushed wrong return address");
   chk_call_low_bits: assert property (
      is_call |=> pc_q[10:0] == $past(dif.kaddr))
      else $error("call target low bits wrong");
   chk_call_page_bits: assert property (
      is_call |=> pc_q[12:11] == $past(pc_page_latch_i[4:3]))
      else $error("call target page bits wrong");
   chk_call_flush: assert property (
      is_call |=> bubble_q && !is_call ##1 !bubble_q)
      else $error("call did not take exactly two cycles");
   chk_call_fetch_new: assert property (
      is_call |=> ##1 pc_q == $past(pc_q) + core_exec_pkg::PC_STEP)
      else $error("fetch after call not sequential from target");
   chk_seq_pc: assert property (
      !is_call |=> pc_q == $past(pc_q) + core_exec_pkg::PC_STEP)
      else $error("program counter did not advance by one");

   // ************************************************************
   // side effects and slot contents
   // ************************************************************
   chk_skip_operand: assert property (
      is_skip |-> rf_addr_o == dif.faddr)
      else $error("skip operand register not addressed");
   chk_skip_drop_word: assert property (
      is_skip && bit_set |=> ##1 ir_q == $past(instr_i))
      else $error("word after skipped one not executed");
   chk_skip_quiet: assert property (
      is_skip |=> !rf_we_o && !push_o && !zero_set_o)
      else $error("skip caused a write or push");
   chk_bubble_cause: assert property (
      !(is_skip && bit_set) && !is_call |=> !bubble_q)
      else $error("no-op forced without skip or call");
   chk_clear_flow: assert property (
      is_clear |=> !bubble_q && ir_q == $past(instr_i))
      else $error("clear disturbed the fetch flow");
   chk_write_cause: assert property (
      !is_clear |=> !rf_we_o && !zero_set_o)
      else $error("write or zero flag without clear");
   chk_zero_with_write: assert property (
      zero_set_o |-> rf_we_o)
      else $error("zero flag pulse without register write");
   chk_push_cause: assert property (
      !is_call |=> !push_o)
      else $error("push without call");
   chk_stack_hold: assert property (
      !is_call |=> $stable(stack_top_o))
      else $error("return address changed without call");
   chk_call_quiet: assert property (
      is_call |=> !rf_we_o && !zero_set_o)
      else $error("call caused a register write");
   chk_call_one_push: assert property (
      is_call |=> ##1 !push_o)
      else $error("call pushed more than once");
   chk_call_slot_nop: assert property (
      is_call |=> ir_q == core_exec_pkg::NOP_WORD)
      else $error("call did not flush the prefetched word");
   chk_call_target_slot: assert property (
      is_call |=> ##1 ir_q == $past(instr_i))
      else $error("word at call target not executed");

   cov_skip_taken: cover property (is_skip && bit_set);
   cov_skip_not: cover property (is_skip && !bit_set);
   cov_clear: cover property (is_clear);
   cov_call: cover property (is_call ##2 is_clear);
   cov_skip_then_clear: cover property (is_skip && !bit_set ##1 is_clear);
endmodule : bit_skip_clear_call_exec

// >>> bit_skip_clear_call_exec_tb_top.sv
// self-checking bench for the skip/clear/call execution block
// assumes program memory and data registers answer combinationally
`timescale 1ns/100ps
module bit_skip_clear_call_exec_tb_top;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic rst_nxt = 1'b1;
   logic [4:0] pc_page_latch_i = 5'h00;
   logic [4:0] latch_nxt = 5'h00;
   logic [13:0] mem [0:8191];
   logic [7:0] rf [0:127];
   logic [13:0] instr_i;
   logic [7:0] rf_rdata_i;
   logic [12:0] pc_o;
   logic [6:0] rf_addr_o;
   logic rf_we_o;
   logic [6:0] rf_waddr_o;
   logic [7:0] rf_wdata_o;
   logic zero_set_o;
   logic push_o;
   logic [12:0] stack_top_o;
   logic bubble_o;
   int n_fail = 0;
   int compares = 0;

   // ************************************************************
   // clock, stimulus registers, memory models
   // ************************************************************
   always #10 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      sys_rst_i <= rst_nxt;
      pc_page_latch_i <= latch_nxt;
   end
   // same-cycle answers, as the core's fetch slot expects
   assign instr_i = mem[pc_o];
   assign rf_rdata_i = rf[rf_addr_o];

   bit_skip_clear_call_exec dut_u (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .instr_i(instr_i),
      .rf_rdata_i(rf_rdata_i),
      .pc_page_latch_i(pc_page_latch_i),
      .pc_o(pc_o),
      .rf_addr_o(rf_addr_o),
      .rf_we_o(rf_we_o),
      .rf_waddr_o(rf_waddr_o),
      .rf_wdata_o(rf_wdata_o),
      .zero_set_o(zero_set_o),
      .push_o(push_o),
      .stack_top_o(stack_top_o),
      .bubble_o(bubble_o)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task step;
      @(posedge ref_clk_i);
      #1;
   endtask : step

   // one cycle later, compare every pulse output at once
   task cyc(input logic we, input logic [6:0] wa, input logic zs,
            input logic pu, input logic bu);
      step;
      chk(rf_we_o, we);
      if (we) begin
         chk(rf_waddr_o, wa);
         chk(rf_wdata_o, 8'h00);
      end
      chk(zero_set_o, zs);
      chk(push_o, pu);
      chk(bubble_o, bu);
   endtask : cyc

   // reset, release, then word 0 sits in the execute slot
   task boot;
      rst_nxt = 1'b1;
      repeat (2) step;
      rst_nxt = 1'b0;
      step;
      chk({push_o, bubble_o, rf_we_o, zero_set_o}, 16'h0000);
      chk(stack_top_o, 13'h0000);
      step;
      chk(pc_o, 13'h0001);
   endtask : boot

   task load_clear(input logic [6:0] f, input logic [12:0] a);
      mem[a] = {core_exec_pkg::CLR_PREFIX, f};
   endtask : load_clear

   // ************************************************************
   // scenarios
   // ************************************************************
   // highest bit of the highest register; the other bits are the opposite
   task test_skip(input logic bitv);
      foreach (mem[i]) mem[i] = 14'h0000;
      rf[127] = bitv ? 8'h80 : 8'h7f;
      mem[0] = {core_exec_pkg::BTSS_PREFIX, 3'h7, 7'h7f};
      load_clear(7'h05, 13'h0001);
      load_clear(7'h06, 13'h0002);
      boot;
      chk(rf_addr_o, 7'h7f);
      if (bitv) begin
         cyc(1'b0, 7'h00, 1'b0, 1'b0, 1'b1);
         chk(pc_o, 13'h0002);
         cyc(1'b0, 7'h00, 1'b0, 1'b0, 1'b0);
      end else begin
         cyc(1'b0, 7'h00, 1'b0, 1'b0, 1'b0);
         cyc(1'b1, 7'h05, 1'b1, 1'b0, 1'b0);
      end
      cyc(1'b1, 7'h06, 1'b1, 1'b0, 1'b0);
      $display("test skip done, bit %0d", bitv);
   endtask : test_skip

   // two calls in a row, each flushing its sequential word
   task test_call;
      foreach (mem[i]) mem[i] = 14'h0000;
      latch_nxt = 5'h17;
      mem[0] = {core_exec_pkg::CALL_PREFIX, 11'h123};
      load_clear(7'h05, 13'h0001);
      mem[13'h1123] = {core_exec_pkg::CALL_PREFIX, 11'h7ff};
      load_clear(7'h05, 13'h1124);
      load_clear(7'h07, 13'h0fff);
      boot;
      cyc(1'b0, 7'h00, 1'b0, 1'b1, 1'b1);
      chk(stack_top_o, 13'h0001);
      chk(pc_o, 13'h1123);
      latch_nxt = 5'h08;
      cyc(1'b0, 7'h00, 1'b0, 1'b0, 1'b0);
      chk(stack_top_o, 13'h0001);
      cyc(1'b0, 7'h00, 1'b0, 1'b1, 1'b1);
      chk(stack_top_o, 13'h1124);
      chk(pc_o, 13'h0fff);
      cyc(1'b0, 7'h00, 1'b0, 1'b0, 1'b0);
      cyc(1'b1, 7'h07, 1'b1, 1'b0, 1'b0);
      $display("test call done");
   endtask : test_call

   // ************************************************************
   // run control
   // ************************************************************
   task finish_test;
      $display("comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   initial begin
      repeat (12) step;
      test_skip(1'b1);
      test_skip(1'b0);
      test_call;
      finish_test;
   end

   // a hang counts as a mismatch
   initial begin
      #200000;
      n_fail++;
      finish_test;
   end
endmodule : bit_skip_clear_call_exec_tb_top

// >>> core_exec_pkg.sv
// constants and types shared by the skip/clear/call execution block
// assumes a 14-bit instruction word, 7-bit file address, 13-bit program counter
package core_exec_pkg;
   // ************************************************************
   // widths
   // ************************************************************
   localparam int INSTR_W = 14;
   localparam int PC_W = 13;
   localparam int FADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int BSEL_W = 3;
   localparam int KADDR_W = 11;
   localparam int LATCH_W = 5;

   // ************************************************************
   // encodings and field positions
   // ************************************************************
   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam logic [3:0] BTSS_PREFIX = 4'h7;
   localparam logic [6:0] CLR_PREFIX = 7'h03;
   localparam logic [2:0] CALL_PREFIX = 3'h4;
   localparam int BSEL_LSB = 7;
   localparam int LATCH_PAGE_LSB = 3;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] PC_STEP = 13'h0001;
   localparam logic [7:0] CLEAR_VALUE = 8'h00;

   typedef enum logic [1:0] {
      OP_OTHER,
      OP_BIT_TEST_SKIP_SET,
      OP_CLEAR_DATA_REGISTER,
      OP_CALL
   } op_kind_t;
endpackage : core_exec_pkg

// >>> decode_if.sv
// carries an instruction word to the decoder and its decoded fields back
// assumes both ends sit on the same clock; the decoder is combinational
`timescale 1ns/100ps
interface decode_if;
   logic [13:0] instr;
   core_exec_pkg::op_kind_t kind;
   logic [6:0] faddr;
   logic [2:0] bsel;
   logic [10:0] kaddr;

   modport dec (
      input instr,
      output kind,
      output faddr,
      output bsel,
      output kaddr
   );
   modport use_side (
      output instr,
      input kind,
      input faddr,
      input bsel,
      input kaddr
   );
endinterface : decode_if

// >>> instr_field_decoder.sv
// combinational opcode and field decoder for the three handled instructions
// assumes the caller presents the word in the execute slot
`timescale 1ns/100ps
module instr_field_decoder (
   decode_if.dec d
);
   localparam int MSB = core_exec_pkg::INSTR_W - 1;
   localparam int SKIP_W = $bits(core_exec_pkg::BTSS_PREFIX);
   localparam int CLR_W = $bits(core_exec_pkg::CLR_PREFIX);
   localparam int CALL_W = $bits(core_exec_pkg::CALL_PREFIX);
   // ************************************************************
   // decode
   // ************************************************************
   always_comb begin
      d.faddr = d.instr[core_exec_pkg::FADDR_W-1:0];
      d.bsel = d.instr[core_exec_pkg::BSEL_LSB +: core_exec_pkg::BSEL_W];
      d.kaddr = d.instr[core_exec_pkg::KADDR_W-1:0];
      if (d.instr[MSB -: SKIP_W] == core_exec_pkg::BTSS_PREFIX) begin
         d.kind = core_exec_pkg::OP_BIT_TEST_SKIP_SET;
      end else if (d.instr[MSB -: CLR_W] == core_exec_pkg::CLR_PREFIX) begin
         d.kind = core_exec_pkg::OP_CLEAR_DATA_REGISTER;
      end else if (d.instr[MSB -: CALL_W] == core_exec_pkg::CALL_PREFIX) begin
         d.kind = core_exec_pkg::OP_CALL;
      end else begin
         d.kind = core_exec_pkg::OP_OTHER;
      end
   end
endmodule : instr_field_decoder
